// file: design/fpcs_defines.svh
/*
 * Constants of the flash program control and status block: register
 * offsets, field positions, keys, reset values and lock encodings.
 * Assumes it is included once, by the package; the design module uses its macros without an include.
 */
`ifndef FPCS_DEFINES_SVH
`define FPCS_DEFINES_SVH

// register offsets on the 8-bit register port
`define FPCS_OFS_CTRL        8'h00
`define FPCS_OFS_STATUS      8'h01
`define FPCS_OFS_BANK        8'h02
`define FPCS_OFS_LOCK        8'h03

// control register fields
`define FPCS_KEY_ARM         4'h5
`define FPCS_KEY_FIRE        4'ha
`define FPCS_CTRL_FPS_BIT    3
`define FPCS_CTRL_RESET      4'h0

// special read mappings (low nibble of the control register)
`define FPCS_MAP_XROW        4'h1
`define FPCS_MAP_SECURITY    4'h4
`define FPCS_MAP_FUSE        4'h5
`define FPCS_XROW_LAST       16'h007f
`define FPCS_SPECIAL_OFS     16'h0000
`define FPCS_UPPER_HALF      16'h8000

// flash operation select codes
`define FPCS_OP_USER         3'h0
`define FPCS_OP_XROW         3'h1
`define FPCS_OP_ERASE        3'h2
`define FPCS_OP_LATCH_RST    3'h3
`define FPCS_OP_SECURITY     3'h4
`define FPCS_OP_FUSE         3'h5

// status register bits
`define FPCS_ST_BUSY         0
`define FPCS_ST_SEQERR       1
`define FPCS_ST_LOADED       2
`define FPCS_ST_USERMAP      3

// lock bits {b2,b1,b0}, programmed bit reads 0
`define FPCS_LOCK_LVL1       3'h7
`define FPCS_LOCK_LVL2       3'h6
`define FPCS_LOCK_LVL3       3'h5
`define FPCS_LOCK_LVL4       3'h3
`define FPCS_LOCK_RESET      3'h3

`define FPCS_BANK_RESET      3'h0
`define FPCS_BANK_LOW        3'h0
`define FPCS_PROG_CYCLES     16'd400

`endif

// file: design/fpcs_pkg.sv
/*
 * Types of the flash program control and status block.
 * Assumes fpcs_defines.svh sits on the include path.
 */
package fpcs_pkg;
   `include "fpcs_defines.svh"

   typedef enum logic [1:0] {
      FPCS_SEQ_IDLE  = 2'b00,
      FPCS_SEQ_ARMED = 2'b01,
      FPCS_SEQ_PROG  = 2'b10
   } fpcs_seq_t;

   typedef enum logic [2:0] {
      FPCS_RD_USER     = 3'b000,
      FPCS_RD_BOOT     = 3'b001,
      FPCS_RD_XROW     = 3'b010,
      FPCS_RD_SECURITY = 3'b011,
      FPCS_RD_FUSE     = 3'b100,
      FPCS_RD_EXTERNAL = 3'b101,
      FPCS_RD_BLOCKED  = 3'b110
   } fpcs_rdtgt_t;

   typedef enum logic [1:0] {
      FPCS_LVL1 = 2'b00,
      FPCS_LVL2 = 2'b01,
      FPCS_LVL3 = 2'b10,
      FPCS_LVL4 = 2'b11
   } fpcs_level_t;
endpackage

// file: design/fpcs_flash_ctrl.sv
/*
 * Control and status for the on-chip program flash: activation pair
 * checking, busy and sequence error flags, power-down handling, code
 * read mapping, data write routing and lock level decoding.
 * Assumes the core drives one-cycle strobes on clk and the external
 * access pin arrives asynchronously.
 */
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps

module fpcs_flash_ctrl
   import fpcs_pkg::*;
#(
   parameter logic [15:0] PROG_CYCLES = `FPCS_PROG_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  regAddr,
   input  wire logic [7:0]  regWrData,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [7:0]  regRdData,
   input  wire logic        movxWr,
   input  wire logic [15:0] movxAddr,
   input  wire logic [7:0]  movxData,
   input  wire logic        movcRd,
   input  wire logic [15:0] movcAddr,
   input  wire logic        fetchExternal,
   input  wire logic        fetchUpperBank,
   input  wire logic        powerDownReq,
   input  wire logic        wakeUp,
   input  wire logic        bootHwEntry,
   input  wire logic        externalAccessPin,
   output logic             flashBusy,
   output logic             sequenceError,
   output logic             latchLoaded,
   output logic             flashSelect,
   output logic             powerDownAck,
   output logic             opStart,
   output logic      [2:0]  opCode,
   output logic      [7:0]  latchWrData,
   output logic             latchWrEn,
   output logic             ramWrEn,
   output logic      [2:0]  readTarget,
   output logic      [2:0]  readBank,
   output logic             readValid,
   output logic      [1:0]  lockLevel,
   output logic             extMovcBlock,
   output logic             parProgBlock,
   output logic             parVerifyBlock,
   output logic             ispWriteBlock,
   output logic             ispReadBlock,
   output logic             extExecBlock
);

   function automatic fpcs_level_t levelOf(input logic [2:0] bits);
      if (bits == `FPCS_LOCK_LVL1) begin
         levelOf = FPCS_LVL1;
      end else if (bits == `FPCS_LOCK_LVL2) begin
         levelOf = FPCS_LVL2;
      end else if (bits == `FPCS_LOCK_LVL3) begin
         levelOf = FPCS_LVL3;
      end else begin
         // unlisted patterns fall back to the strongest protection
         levelOf = FPCS_LVL4;
      end
   endfunction

   function automatic logic isProgOp(input logic [2:0] op);
      isProgOp = (op == `FPCS_OP_USER) || (op == `FPCS_OP_XROW) ||
                 (op == `FPCS_OP_ERASE) || (op == `FPCS_OP_SECURITY) ||
                 (op == `FPCS_OP_FUSE);
   endfunction

   // registers
   fpcs_seq_t   seqState_reg;
   fpcs_seq_t   seqState_next;
   logic [3:0]  ctrl_reg;
   logic [3:0]  ctrl_next;
   logic        busy_reg;
   logic        busy_next;
   logic        seqErr_reg;
   logic        seqErr_next;
   logic        loaded_reg;
   logic        loaded_next;
   logic        userMap_reg;
   logic        userMap_next;
   logic        bootMap_reg;
   logic        select_reg;
   logic        select_next;
   logic [2:0]  bank_reg;
   logic [2:0]  lockBits_reg;
   logic [2:0]  pendLock_reg;
   logic [2:0]  curOp_reg;
   logic [15:0] progCnt_reg;
   logic [15:0] progCnt_next;
   logic        rstSeen_reg;
   logic        eaLatched_reg;
   logic        eaS1_reg;
   logic        eaS2_reg;
   logic        eaS3_reg;
   logic        eaStable_reg;
   logic [7:0]  rdData_reg;
   logic        pdAck_reg;
   logic        opStart_reg;
   logic [2:0]  opCode_reg;
   logic        latchWr_reg;
   logic [7:0]  latchData_reg;
   logic        ramWr_reg;
   logic [2:0]  rdTgt_reg;
   logic [2:0]  rdBank_reg;
   logic        rdValid_reg;

   // decode
   wire         wrCtrl    = regWr && (regAddr == `FPCS_OFS_CTRL);
   wire         wrStatus  = regWr && (regAddr == `FPCS_OFS_STATUS);
   wire         wrBank    = regWr && (regAddr == `FPCS_OFS_BANK);
   wire  [3:0]  wrKey     = regWrData[7:4];
   wire  [2:0]  wrOp      = regWrData[2:0];
   wire         isArm     = wrCtrl && (wrKey == `FPCS_KEY_ARM);
   wire         isFire    = wrCtrl && (wrKey == `FPCS_KEY_FIRE);
   // anything else on the port or the core buses breaks the pair
   wire         otherAcc  = (regWr && !wrCtrl) || regRd || movxWr || movcRd;
   wire         pairOk    = (seqState_reg == FPCS_SEQ_ARMED) && isFire;
   wire         pairBad   = (seqState_reg == FPCS_SEQ_ARMED) &&
                            ((wrCtrl && !isFire) || otherAcc);
   wire         needsData = isProgOp(wrOp) || (wrOp == `FPCS_OP_LATCH_RST);
   wire         emptyErr  = pairOk && needsData && !loaded_reg;
   wire         launch    = pairOk && isProgOp(wrOp) && loaded_reg && !busy_reg;
   wire         latchRst  = pairOk && (wrOp == `FPCS_OP_LATCH_RST) && loaded_reg;
   wire         progDone  = (seqState_reg == FPCS_SEQ_PROG) &&
                            (progCnt_reg == PROG_CYCLES - 16'd1);

   fpcs_level_t level;
   assign level = levelOf(lockBits_reg);
   wire         lvl2Up    = (level != FPCS_LVL1);
   wire         lvl3Up    = (level == FPCS_LVL3) || (level == FPCS_LVL4);
   wire         lvl4Up    = (level == FPCS_LVL4);
   // at level 2 and above the pin value caught at reset is used
   wire         eaEff     = lvl2Up ? eaLatched_reg : eaStable_reg;

   wire         pdAccept  = powerDownReq && !busy_reg;
   wire         latch_space_map_bit       = ctrl_reg[`FPCS_CTRL_FPS_BIT];
   wire         toLatch   = movxWr && latch_space_map_bit && eaEff;
   wire         toRam     = movxWr && !(latch_space_map_bit && eaEff);
   // a load during programming is dropped, old latch data kept
   wire         latchTake = toLatch && !busy_reg;

   // code read mapping
   wire         upperAddr = (movcAddr >= `FPCS_UPPER_HALF);
   wire         isSpecOfs = (movcAddr == `FPCS_SPECIAL_OFS);
   fpcs_rdtgt_t rdTgt;
   logic [2:0]  rdBank;
   always_comb begin
      rdTgt  = FPCS_RD_USER;
      rdBank = `FPCS_BANK_LOW;
      if (fetchExternal) begin
         if (!eaEff || lvl4Up) begin
            rdTgt = FPCS_RD_EXTERNAL;
         end else if (fetchUpperBank && upperAddr) begin
            rdTgt = FPCS_RD_EXTERNAL;
         end else if (lvl2Up) begin
            rdTgt = FPCS_RD_BLOCKED;
         end else begin
            rdBank = upperAddr ? bank_reg : `FPCS_BANK_LOW;
         end
      end else if (ctrl_reg == `FPCS_MAP_XROW && movcAddr <= `FPCS_XROW_LAST) begin
         rdTgt = FPCS_RD_XROW;
      end else if (ctrl_reg == `FPCS_MAP_SECURITY && isSpecOfs) begin
         rdTgt = FPCS_RD_SECURITY;
      end else if (ctrl_reg == `FPCS_MAP_FUSE && isSpecOfs) begin
         rdTgt = FPCS_RD_FUSE;
      end else if (bootMap_reg && !userMap_reg) begin
         rdTgt = FPCS_RD_BOOT;
      end else begin
         rdBank = upperAddr ? bank_reg : `FPCS_BANK_LOW;
      end
   end

   // sequencer
   always_comb begin
      seqState_next = seqState_reg;
      progCnt_next  = progCnt_reg;
      busy_next     = busy_reg;
      case (seqState_reg)
         FPCS_SEQ_IDLE: begin
            if (isArm) begin
               seqState_next = FPCS_SEQ_ARMED;
            end
         end
         FPCS_SEQ_ARMED: begin
            if (launch) begin
               seqState_next = FPCS_SEQ_PROG;
               busy_next     = 1'b1;
               progCnt_next  = 16'd0;
            end else if (isArm) begin
               seqState_next = FPCS_SEQ_ARMED;
            end else if (wrCtrl || otherAcc) begin
               seqState_next = busy_reg ? FPCS_SEQ_PROG : FPCS_SEQ_IDLE;
            end
         end
         FPCS_SEQ_PROG: begin
            progCnt_next = progCnt_reg + 16'd1;
            if (progDone) begin
               seqState_next = FPCS_SEQ_IDLE;
               busy_next     = 1'b0;
            end else if (isArm) begin
               // a new pair may be armed; a fire while busy does not launch
               seqState_next = FPCS_SEQ_ARMED;
            end
         end
         default: begin
            seqState_next = FPCS_SEQ_IDLE;
         end
      endcase
      // armed while a write runs: counting continues, done still clears
      if (seqState_reg == FPCS_SEQ_ARMED && busy_reg) begin
         progCnt_next = progCnt_reg + 16'd1;
         if (progCnt_reg == PROG_CYCLES - 16'd1) begin
            busy_next = 1'b0;
         end
      end
   end

   // flags: hardware set wins over software clear
   always_comb begin
      seqErr_next = seqErr_reg;
      if (wrStatus && !regWrData[`FPCS_ST_SEQERR]) begin
         seqErr_next = 1'b0;
      end
      if (pairOk && !emptyErr) begin
         seqErr_next = 1'b0;
      end
      if (pairBad || emptyErr) begin
         seqErr_next = 1'b1;
      end
   end

   always_comb begin
      loaded_next = loaded_reg;
      // a launch keeps the latches, a latch reset or an accepted power-down empties them
      if (latchRst) begin
         loaded_next = 1'b0;
      end
      if (pdAccept) begin
         loaded_next = 1'b0;
      end else if (latchTake) begin
         loaded_next = 1'b1;
      end
   end

   always_comb begin
      userMap_next = userMap_reg;
      if (wrStatus) begin
         userMap_next = regWrData[`FPCS_ST_USERMAP];
      end else if (movcRd && !fetchExternal && rdTgt == FPCS_RD_USER && bootMap_reg) begin
         // boot code has to remap before every user read
         userMap_next = 1'b0;
      end
   end

   always_comb begin
      select_next = select_reg;
      if (pdAccept) begin
         select_next = 1'b0;
      end else if (wakeUp) begin
         select_next = 1'b1;
      end
   end

   always_comb begin
      ctrl_next = ctrl_reg;
      if (wrCtrl) begin
         // writing zero brings back the normal user mapping
         ctrl_next = regWrData[3:0];
      end
   end

   // read port
   logic [7:0] rdMux;
   always_comb begin
      rdMux = 8'h00;
      if (regAddr == `FPCS_OFS_CTRL) begin
         rdMux = {4'h0, ctrl_reg};
      end else if (regAddr == `FPCS_OFS_STATUS) begin
         rdMux = {4'h0, userMap_reg, loaded_reg, seqErr_reg, busy_reg};
      end else if (regAddr == `FPCS_OFS_BANK) begin
         rdMux = {5'h00, bank_reg};
      end else if (regAddr == `FPCS_OFS_LOCK) begin
         rdMux = {5'h00, lockBits_reg};
      end
   end

   // pin synchroniser, a change counts once stages two and three agree
   always_ff @(posedge clk) begin
      eaS1_reg <= externalAccessPin;
      eaS2_reg <= eaS1_reg;
      eaS3_reg <= eaS2_reg;
      if (eaS2_reg == eaS3_reg) begin
         eaStable_reg <= eaS3_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         seqState_reg <= FPCS_SEQ_IDLE;
         progCnt_reg  <= 16'd0;
         busy_reg     <= 1'b0;
         seqErr_reg   <= 1'b0;
         loaded_reg   <= 1'b0;
         userMap_reg  <= 1'b0;
         select_reg   <= 1'b1;
         ctrl_reg     <= `FPCS_CTRL_RESET;
         curOp_reg    <= `FPCS_OP_USER;
      end else begin
         seqState_reg <= seqState_next;
         progCnt_reg  <= progCnt_next;
         busy_reg     <= busy_next;
         seqErr_reg   <= seqErr_next;
         loaded_reg   <= loaded_next;
         userMap_reg  <= userMap_next;
         select_reg   <= select_next;
         ctrl_reg     <= ctrl_next;
         if (launch) begin
            curOp_reg <= wrOp;
         end
      end
   end

   // straps caught on the first edge after reset release
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rstSeen_reg   <= 1'b0;
         bootMap_reg   <= 1'b0;
         eaLatched_reg <= 1'b0;
      end else if (!rstSeen_reg) begin
         rstSeen_reg   <= 1'b1;
         bootMap_reg   <= bootHwEntry;
         eaLatched_reg <= eaStable_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bank_reg     <= `FPCS_BANK_RESET;
         lockBits_reg <= `FPCS_LOCK_RESET;
         pendLock_reg <= `FPCS_LOCK_LVL1;
      end else begin
         if (wrBank) begin
            bank_reg <= regWrData[2:0];
         end
         if (latchTake && ctrl_reg[2:0] == `FPCS_OP_SECURITY) begin
            pendLock_reg <= movxData[2:0];
         end
         if (progDone && curOp_reg == `FPCS_OP_SECURITY) begin
            // bits only go to programmed without a full erase
            lockBits_reg <= lockBits_reg & pendLock_reg;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdData_reg    <= 8'h00;
         pdAck_reg     <= 1'b0;
         opStart_reg   <= 1'b0;
         opCode_reg    <= `FPCS_OP_USER;
         latchWr_reg   <= 1'b0;
         latchData_reg <= 8'h00;
         ramWr_reg     <= 1'b0;
         rdTgt_reg     <= FPCS_RD_USER;
         rdBank_reg    <= `FPCS_BANK_LOW;
         rdValid_reg   <= 1'b0;
      end else begin
         rdData_reg    <= regRd ? rdMux : 8'h00;
         pdAck_reg     <= pdAccept;
         opStart_reg   <= launch;
         opCode_reg    <= launch ? wrOp : opCode_reg;
         latchWr_reg   <= latchTake;
         latchData_reg <= latchTake ? movxData : latchData_reg;
         ramWr_reg     <= toRam;
         rdTgt_reg     <= movcRd ? rdTgt : rdTgt_reg;
         rdBank_reg    <= movcRd ? rdBank : rdBank_reg;
         rdValid_reg   <= movcRd;
      end
   end

   // protection outputs follow the decoded level
   logic [1:0] lockLevel_reg;
   logic [5:0] prot_reg;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lockLevel_reg <= FPCS_LVL4;
         prot_reg      <= 6'h3f;
      end else begin
         lockLevel_reg <= level;
         prot_reg      <= {lvl4Up,
                           lvl3Up, lvl3Up,
                           lvl2Up, lvl2Up, lvl2Up};
      end
   end

   assign regRdData      = rdData_reg;
   assign flashBusy      = busy_reg;
   assign sequenceError  = seqErr_reg;
   assign latchLoaded    = loaded_reg;
   assign flashSelect    = select_reg;
   assign powerDownAck   = pdAck_reg;
   assign opStart        = opStart_reg;
   assign opCode         = opCode_reg;
   assign latchWrEn      = latchWr_reg;
   assign latchWrData    = latchData_reg;
   assign ramWrEn        = ramWr_reg;
   assign readTarget     = rdTgt_reg;
   assign readBank       = rdBank_reg;
   assign readValid      = rdValid_reg;
   assign lockLevel      = lockLevel_reg;
   assign extMovcBlock   = prot_reg[0];
   assign parProgBlock   = prot_reg[1];
   assign ispWriteBlock  = prot_reg[2];
   assign parVerifyBlock = prot_reg[3];
   assign ispReadBlock   = prot_reg[4];
   assign extExecBlock   = prot_reg[5];

endmodule

// file: dv/fpcs_flash_ctrl_sva.sv
/* Port checker of fpcs_flash_ctrl.
   Assumes it is bound to that module and sees one clk domain. */
`timescale 1ns/1ps
module fpcs_flash_ctrl_sva (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        movxWr,
   input wire logic        movcRd,
   input wire logic [15:0] movcAddr,
   input wire logic        fetchExternal,
   input wire logic        fetchUpperBank,
   input wire logic        powerDownReq,
   input wire logic        flashBusy,
   input wire logic        sequenceError,
   input wire logic        latchLoaded,
   input wire logic        flashSelect,
   input wire logic        powerDownAck,
   input wire logic        opStart,
   input wire logic        latchWrEn,
   input wire logic        ramWrEn,
   input wire logic [2:0]  readTarget,
   input wire logic        readValid,
   input wire logic [1:0]  lockLevel,
   input wire logic        parVerifyBlock,
   input wire logic        extExecBlock
);
   default clocking dcb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   AST_PD_ACK: assert property (powerDownReq && !flashBusy
      |=> powerDownAck && !flashSelect && !latchLoaded) else $error("power-down not taken");
   AST_PD_BUSY: assert property (powerDownReq && flashBusy |=> !powerDownAck)
      else $error("power-down taken while busy");
   AST_BUSY_ST: assert property ($rose(flashBusy) |-> opStart)
      else $error("busy without a launch");
   AST_START_OK: assert property (opStart |-> flashBusy && !sequenceError)
      else $error("launch without busy or with error");
   AST_MOVX: assert property (movxWr && !flashBusy |=> latchWrEn != ramWrEn)
      else $error("data write not routed once");
   AST_RVALID: assert property (movcRd |=> readValid)
      else $error("code read not answered");
   AST_EXT_HI: assert property (movcRd && fetchExternal && fetchUpperBank
      && movcAddr >= 16'h8000 |=> readTarget == 3'h5) else $error("upper read not external");
   AST_LVL4: assert property (extExecBlock == (lockLevel == 2'h3))
      else $error("external execution block wrong");
   AST_LVL3: assert property (parVerifyBlock == lockLevel[1])
      else $error("verify block wrong");
   cover property (opStart);
   cover property (powerDownAck);
   cover property (latchWrEn);
endmodule
bind fpcs_flash_ctrl fpcs_flash_ctrl_sva fpcs_flash_ctrl_sva_i (
   .clk, .sys_rst, .movxWr, .movcRd, .movcAddr, .fetchExternal, .fetchUpperBank,
   .powerDownReq, .flashBusy, .sequenceError, .latchLoaded, .flashSelect,
   .powerDownAck, .opStart, .latchWrEn, .ramWrEn, .readTarget, .readValid,
   .lockLevel, .parVerifyBlock, .extExecBlock
);

// file: dv/fpcs_core_model.sv
/* Core model: data and code memory accesses, power requests.
   Assumes clk is the block clock; calls come from the bench. */
`timescale 1ns/1ps
module fpcs_core_model (
   input  wire logic        clk,
   output logic             movxWr            = 1'b0,
   output logic [15:0]      movxAddr          = 16'h0000,
   output logic [7:0]       movxData          = 8'h00,
   output logic             movcRd            = 1'b0,
   output logic [15:0]      movcAddr          = 16'h0000,
   output logic             fetchExternal     = 1'b0,
   output logic             fetchUpperBank    = 1'b0,
   output logic             powerDownReq      = 1'b0,
   output logic             wakeUp            = 1'b0,
   output logic             bootHwEntry       = 1'b0,
   output logic             externalAccessPin = 1'b1
);
   // lock levels 2 and 3 are never programmed by this core
   task automatic movx(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      movxAddr <= a;
      movxData <= d;
      movxWr   <= 1'b1;
      @(posedge clk);
      movxWr   <= 1'b0;
      // stale bus values must not look valid
      movxAddr <= ~a;
      movxData <= ~d;
      #1;
   endtask
   task automatic movc(input logic [15:0] a);
      @(posedge clk);
      movcAddr <= a;
      movcRd   <= 1'b1;
      @(posedge clk);
      movcRd   <= 1'b0;
      movcAddr <= ~a;
      #1;
   endtask
   task automatic pulse(input logic w);
      @(posedge clk);
      powerDownReq <= !w;
      wakeUp       <= w;
      @(posedge clk);
      powerDownReq <= 1'b0;
      wakeUp       <= 1'b0;
      #1;
   endtask
   task automatic mode(input logic e, input logic u, input logic b);
      @(posedge clk);
      fetchExternal  <= e;
      fetchUpperBank <= u;
      bootHwEntry    <= b;
   endtask
   task automatic pin(input logic p);
      @(posedge clk);
      externalAccessPin <= p;
   endtask
endmodule

// file: dv/fpcs_flash_ctrl_test.sv
/* Self-checking bench of fpcs_flash_ctrl with a core model.
   Assumes a short programming time for a quick run. */
`timescale 1ns/1ps
module fpcs_flash_ctrl_test;
   import fpcs_pkg::*;
   logic        clk, sysRst = 1'b1, regWr = 1'b0, regRd = 1'b0;
   logic [7:0]  regAddr = 8'h00, regWrData = 8'h00, regRdData, latchWrData;
   logic        movxWr, movcRd, fetchExternal, fetchUpperBank, powerDownReq;
   logic        wakeUp, bootHwEntry, externalAccessPin, flashBusy, sequenceError;
   logic        latchLoaded, flashSelect, powerDownAck, opStart, latchWrEn;
   logic        ramWrEn, readValid, extExecBlock, extMovcBlock, parProgBlock;
   logic        parVerifyBlock, ispWriteBlock, ispReadBlock;
   logic [15:0] movxAddr, movcAddr;
   logic [7:0]  movxData, d;
   logic [2:0]  opCode, readTarget, readBank;
   logic [1:0]  lockLevel;
   int          num_errors = 0, total_checks = 0, cycles = 0, n, i;
   logic [7:0]  mapCtl [5] = '{8'h01, 8'h01, 8'h04, 8'h05, 8'h00};
   logic [15:0] mapAdr [5] = '{16'h007f, 16'h0080, 16'h0000, 16'h0000, 16'h0000};
   logic [2:0]  mapTgt [5] = '{3'h2, 3'h0, 3'h3, 3'h4, 3'h0};
   fpcs_flash_ctrl #(.PROG_CYCLES(16'd8)) fpcs_flash_ctrl_i (
      .clk, .sys_rst(sysRst), .regAddr, .regWrData, .regWr, .regRd, .regRdData,
      .movxWr, .movxAddr, .movxData, .movcRd, .movcAddr, .fetchExternal,
      .fetchUpperBank, .powerDownReq, .wakeUp, .bootHwEntry, .externalAccessPin,
      .flashBusy, .sequenceError, .latchLoaded, .flashSelect, .powerDownAck,
      .opStart, .opCode, .latchWrData, .latchWrEn, .ramWrEn, .readTarget,
      .readBank, .readValid, .lockLevel, .extMovcBlock, .parProgBlock,
      .parVerifyBlock, .ispWriteBlock, .ispReadBlock, .extExecBlock);
   fpcs_core_model fpcs_core_model_i (
      .clk, .movxWr, .movxAddr, .movxData, .movcRd, .movcAddr, .fetchExternal,
      .fetchUpperBank, .powerDownReq, .wakeUp, .bootHwEntry, .externalAccessPin);
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic print_verdict();
      if (num_errors == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ceiling well above the roughly 120 cycles of the run
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         print_verdict();
      end
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      regAddr   <= a;
      regWrData <= v;
      regWr     <= 1'b1;
      @(posedge clk);
      regWr     <= 1'b0;
      #1;
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge clk);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge clk);
      regRd   <= 1'b0;
      #1 d = regRdData;
      chk(16'(d & m), 16'(e));
   endtask
   task automatic rst();
      @(posedge clk);
      sysRst <= 1'b1;
      repeat (4) @(posedge clk);
      sysRst <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   initial begin
      rst();
      rdChk(8'h03, 8'hff, 8'h03);
      chk(16'({lockLevel, extExecBlock, ispReadBlock, parVerifyBlock}), 16'h1f);
      chk(16'({ispWriteBlock, parProgBlock, extMovcBlock}), 16'h7);
      rdChk(8'h07, 8'hff, 8'h00);
      wr(8'h00, 8'h50);
      wr(8'h00, 8'ha0);
      rdChk(8'h01, 8'h07, 8'h02);
      wr(8'h01, 8'h00);
      rdChk(8'h01, 8'h02, 8'h00);
      wr(8'h00, 8'h50);
      rdChk(8'h07, 8'hff, 8'h00);
      rdChk(8'h01, 8'h02, 8'h02);
      wr(8'h01, 8'h00);
      wr(8'h00, 8'h08);
      fpcs_core_model_i.movx(16'h0010, 8'h5a);
      chk(16'({latchWrEn, ramWrEn, latchWrData}), 16'h025a);
      wr(8'h00, 8'h50);
      wr(8'h00, 8'ha0);
      chk(16'({flashBusy, opStart, opCode, sequenceError}), 16'h30);
      fpcs_core_model_i.pulse(1'b0);
      chk(16'({powerDownAck, flashSelect}), 16'h1);
      n = 2;
      while (flashBusy === 1'b1 && n < 100) begin
         @(posedge clk);
         #1 n++;
      end
      chk(16'(n), 16'd8);
      rdChk(8'h01, 8'h07, 8'h04);
      fpcs_core_model_i.pulse(1'b0);
      chk(16'({powerDownAck, flashSelect, latchLoaded}), 16'h4);
      fpcs_core_model_i.pulse(1'b1);
      chk(16'(flashSelect), 16'h1);
      wr(8'h00, 8'h53);
      wr(8'h00, 8'ha3);
      rdChk(8'h01, 8'h02, 8'h02);
      wr(8'h00, 8'h08);
      fpcs_core_model_i.movx(16'h0020, 8'h11);
      wr(8'h00, 8'h53);
      wr(8'h00, 8'ha3);
      rdChk(8'h01, 8'h06, 8'h00);
      for (i = 0; i < 5; i++) begin
         wr(8'h00, mapCtl[i]);
         fpcs_core_model_i.movc(mapAdr[i]);
         chk(16'({readValid, readTarget}), 16'({1'b1, mapTgt[i]}));
      end
      wr(8'h02, 8'h05);
      fpcs_core_model_i.movc(16'h8000);
      chk(16'(readBank), 16'h5);
      fpcs_core_model_i.mode(1'b1, 1'b1, 1'b0);
      fpcs_core_model_i.movc(16'h9000);
      chk(16'(readTarget), 16'h5);
      fpcs_core_model_i.movc(16'h1000);
      chk(16'(readTarget), 16'h5);
      fpcs_core_model_i.pin(1'b0);
      fpcs_core_model_i.mode(1'b0, 1'b0, 1'b1);
      rst();
      // pin goes back high; the value caught at reset must still rule
      fpcs_core_model_i.pin(1'b1);
      fpcs_core_model_i.movc(16'h0000);
      chk(16'(readTarget), 16'h1);
      wr(8'h01, 8'h08);
      fpcs_core_model_i.movc(16'h0000);
      chk(16'(readTarget), 16'h0);
      fpcs_core_model_i.movc(16'h0000);
      chk(16'(readTarget), 16'h1);
      wr(8'h00, 8'h08);
      fpcs_core_model_i.movx(16'h0030, 8'h3c);
      chk(16'({latchWrEn, ramWrEn, latchWrData}), 16'h0100);
      print_verdict();
   end
endmodule
